/* File: src/acc_pkg.sv */
package acc_pkg;
	// converter word and split between frozen low bits and free-running high bits
	localparam int CODE_W      = 10;
	localparam int LOW_W       = 5;
	// pipeline latency in sample clocks
	localparam int LATENCY     = 3;
	// calibration sequence timing, cycles after edge detect
	localparam int CAL_LEN     = 11;
	localparam int CAL_HOLD_AT = 7;
	localparam int CAL_HOLD_N  = 4;
	// pulses that make one complete calibration
	localparam int CAL_STEPS   = 7;
	// clock divider and counters
	localparam int DIV_W       = 4;
	localparam int PWR_W       = 14;
	localparam int PER_W       = 24;
	// buffer depth in words
	localparam int FIFO_DEPTH  = 16;
	// reset values
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
	localparam logic [3:0]        CNT4_RST = 4'h0;

	// sample word with its calibration-hold marker
	typedef struct packed {
		logic              cal_hold;
		logic [CODE_W-1:0] code;
	} acc_sample_t;

	// calibration sequence phases
	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_RUN,
		CAL_HOLD,
		CAL_TAIL
	} acc_cal_state_t;
endpackage : acc_pkg

/* File: src/acc_fifo.sv */
`timescale 1ns/1ps
// small flip-flop fifo, valid/ready on both sides
module acc_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];  // storage
	logic [WIDTH-1:0] mem_nxt;        // word written this cycle
	logic [AW-1:0]    wp_r, wp_nxt;   // write index
	logic [AW-1:0]    rp_r, rp_nxt;   // read index
	logic [AW:0]      cnt_r, cnt_nxt; // fill level
	logic             push, pop;

	// honest full and empty; an empty buffer must still accept
	assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];

	// pointer and level update
	always_comb begin
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		mem_nxt = in_data;
	end

	// registers only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage has no reset; contents are qualified by the level
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= mem_nxt;
		end
	end
endmodule : acc_fifo

/* File: src/acc_ctrl.sv */
`timescale 1ns/1ps
module acc_ctrl (
	// clock and reset
	input  wire logic                          SYS_CLK,
	input  wire logic                          RST_B,
	// calibration control pins
	input  wire logic                          CAL_PULSE,
	input  wire logic                          CAL_SRC_SEL,
	input  wire logic                          CHIP_EN_B,
	input  wire logic                          CAL_RESET,
	// raw comparator result from the analog core
	input  wire logic [acc_pkg::CODE_W-1:0]    RAW_CODE,
	// output stream
	output logic      [acc_pkg::CODE_W-1:0]    SAMPLE_CODE_OUT,
	output logic                               SAMPLE_VALID,
	input  wire logic                          SAMPLE_READY,
	// status
	output logic                               CAL_BUSY,
	output logic                               CAL_HOLD_ACTIVE,
	output logic                               PWRUP_DONE,
	output logic      [2:0]                    CAL_STEP,
	output logic                               SAMPLE_STALL
);
	// synchronisers for pins
	logic        cal_s1_r, cal_s2_r, cal_prev_r;
	logic        sel_s1_r, sel_s2_r;
	logic        ceb_s1_r, ceb_s2_r;
	logic        rst_s1_r, rst_s2_r;
	// clock divider and counters
	logic [acc_pkg::DIV_W-1:0] div_r, div_nxt;
	logic [acc_pkg::PWR_W:0]   pwr_r, pwr_nxt;   // msb is carry, stops power-up
	logic [acc_pkg::PER_W-1:0] per_r, per_nxt;
	logic                      tick16;           // clk/16 strobe
	logic                      en_ok;            // power-up enabled
	logic                      en_ok_d_r;        // for restart detection
	logic                      int_pulse;        // periodic internal pulse
	logic                      pwr_pulse;        // power-up pulse
	logic                      fall;             // external falling edge
	// sequence state
	acc_pkg::acc_cal_state_t   st_r, st_nxt;
	logic [3:0]                seq_r, seq_nxt;   // cycle in 11-cycle run
	logic [2:0]                step_r, step_nxt; // pulse count of seven
	// pipeline
	logic [acc_pkg::CODE_W-1:0] pipe_r [acc_pkg::LATENCY];
	logic [acc_pkg::CODE_W-1:0] pipe_nxt;
	logic [acc_pkg::LOW_W-1:0]  low_hold_r, low_hold_nxt;
	logic                       hold;
	// buffer
	acc_pkg::acc_sample_t       fin;
	acc_pkg::acc_sample_t       fout;
	logic                       f_ready;
	logic                       f_valid;
	logic                       out_valid_r;

	// pins pass two flops and the second stage is read; the calibration pin also feeds a third flop for the edge
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cal_s1_r   <= 1'b1;
			cal_s2_r   <= 1'b1;
			cal_prev_r <= 1'b1;
			sel_s1_r   <= 1'b0;
			sel_s2_r   <= 1'b0;
			ceb_s1_r   <= 1'b1;
			ceb_s2_r   <= 1'b1;
			rst_s1_r   <= 1'b0;
			rst_s2_r   <= 1'b0;
		end else begin
			cal_s1_r   <= CAL_PULSE;
			cal_s2_r   <= cal_s1_r;
			cal_prev_r <= cal_s2_r;
			sel_s1_r   <= CAL_SRC_SEL;
			sel_s2_r   <= sel_s1_r;
			ceb_s1_r   <= CHIP_EN_B;
			ceb_s2_r   <= ceb_s1_r;
			rst_s1_r   <= CAL_RESET;
			rst_s2_r   <= rst_s1_r;
		end
	end

	// pulse generation
	always_comb begin
		en_ok     = rst_s2_r && !ceb_s2_r;
		tick16    = (div_r == 4'hF);
		div_nxt   = en_ok ? div_r + 1'b1 : acc_pkg::CNT4_RST;
		pwr_pulse = en_ok && tick16 && !pwr_r[acc_pkg::PWR_W];
		pwr_nxt   = pwr_r;
		// enable or reset toggle restarts power-up
		if (!en_ok) begin
			pwr_nxt = '0;
		end else if (pwr_pulse) begin
			pwr_nxt = pwr_r + 1'b1;
		end
		per_nxt   = per_r;
		int_pulse = 1'b0;
		if (en_ok && tick16 && pwr_r[acc_pkg::PWR_W] && sel_s2_r) begin
			per_nxt   = per_r + 1'b1;
			int_pulse = (per_r == '1);
		end
		fall = cal_prev_r && !cal_s2_r && !sel_s2_r;
	end

	// counters, registered
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_r     <= acc_pkg::CNT4_RST;
			pwr_r     <= '0;
			per_r     <= '0;
			en_ok_d_r <= 1'b0;
		end else begin
			div_r     <= div_nxt;
			pwr_r     <= pwr_nxt;
			per_r     <= per_nxt;
			en_ok_d_r <= en_ok;
		end
	end

	// calibration sequence; any pulse source starts the 11-cycle run
	always_comb begin
		st_nxt   = st_r;
		seq_nxt  = seq_r;
		step_nxt = step_r;
		unique case (st_r)
			acc_pkg::CAL_IDLE: begin
				if (fall || int_pulse || pwr_pulse) begin
					st_nxt  = acc_pkg::CAL_RUN;
					seq_nxt = 4'h1;
				end
			end
			acc_pkg::CAL_RUN: begin
				seq_nxt = seq_r + 1'b1;
				if (seq_r == 4'(acc_pkg::CAL_HOLD_AT - 1)) begin
					st_nxt = acc_pkg::CAL_HOLD;
				end
			end
			acc_pkg::CAL_HOLD: begin
				seq_nxt = seq_r + 1'b1;
				if (seq_r == 4'(acc_pkg::CAL_HOLD_AT + acc_pkg::CAL_HOLD_N - 1)) begin
					st_nxt = acc_pkg::CAL_TAIL;
				end
			end
			acc_pkg::CAL_TAIL: begin
				st_nxt  = acc_pkg::CAL_IDLE;
				seq_nxt = 4'h0;
				step_nxt = (step_r == 3'(acc_pkg::CAL_STEPS - 1)) ? 3'h0 : step_r + 1'b1;
			end
		endcase
		if (!en_ok && en_ok_d_r) begin
			step_nxt = 3'h0;
		end
	end

	// sequence registers
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r   <= acc_pkg::CAL_IDLE;
			seq_r  <= 4'h0;
			step_r <= 3'h0;
		end else begin
			st_r   <= st_nxt;
			seq_r  <= seq_nxt;
			step_r <= step_nxt;
		end
	end

	// data pipeline; low bits frozen during hold
	always_comb begin
		hold         = (st_r == acc_pkg::CAL_HOLD);
		low_hold_nxt = hold ? low_hold_r : pipe_r[acc_pkg::LATENCY-2][acc_pkg::LOW_W-1:0];
		pipe_nxt = {pipe_r[acc_pkg::LATENCY-2][acc_pkg::CODE_W-1:acc_pkg::LOW_W],
			hold ? low_hold_r : pipe_r[acc_pkg::LATENCY-2][acc_pkg::LOW_W-1:0]};
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pipe_r[0]   <= acc_pkg::CODE_RST;
			pipe_r[1]   <= acc_pkg::CODE_RST;
			pipe_r[2]   <= acc_pkg::CODE_RST;
			low_hold_r  <= '0;
			out_valid_r <= 1'b0;
		end else begin
			pipe_r[0]   <= RAW_CODE;
			pipe_r[1]   <= pipe_r[0];
			pipe_r[2]   <= pipe_nxt;
			low_hold_r  <= low_hold_nxt;
			out_valid_r <= 1'b1;
		end
	end

	// buffer after the pipeline; a stalled reader loses nothing until full
	// one driver for the whole carrier word
	assign fin = '{cal_hold: hold, code: pipe_r[acc_pkg::LATENCY-1]};

	acc_fifo #(
		.WIDTH ($bits(acc_pkg::acc_sample_t)),
		.DEPTH (acc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst_b     (RST_B),
		.in_valid  (out_valid_r),
		.in_ready  (f_ready),
		.in_data   (fin),
		.out_valid (f_valid),
		.out_ready (SAMPLE_READY),
		.out_data  (fout)
	);

	// outputs
	assign SAMPLE_CODE_OUT = fout.code;
	assign SAMPLE_VALID    = f_valid;
	assign SAMPLE_STALL    = out_valid_r && !f_ready;
	assign CAL_BUSY        = (st_r != acc_pkg::CAL_IDLE);
	assign CAL_HOLD_ACTIVE = hold;
	assign PWRUP_DONE      = pwr_r[acc_pkg::PWR_W];
	assign CAL_STEP        = step_r;

	// edge-to-run within one cycle
	property p_start;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(st_r == acc_pkg::CAL_IDLE) && fall |=> (st_r == acc_pkg::CAL_RUN);
	endproperty
	a_start: assert property (p_start) else $error("edge did not start calibration");

	// run lasts eleven cycles, split to keep each repetition short
	property p_len;
		@(posedge SYS_CLK) disable iff (!RST_B)
		$rose(CAL_BUSY) |-> CAL_BUSY [*8] ##1 CAL_BUSY [*3] ##1 !CAL_BUSY;
	endproperty
	a_len: assert property (p_len) else $error("calibration length wrong");

	// hold four cycles after six run cycles
	property p_hold;
		@(posedge SYS_CLK) disable iff (!RST_B)
		$rose(CAL_BUSY) |-> !hold [*6] ##1 hold [*4] ##1 !hold;
	endproperty
	a_hold: assert property (p_hold) else $error("hold window wrong");

	// low bits stay frozen
	property p_low;
		@(posedge SYS_CLK) disable iff (!RST_B)
		hold && $past(hold) |-> pipe_r[2][4:0] == $past(pipe_r[2][4:0]);
	endproperty
	a_low: assert property (p_low) else $error("low bits moved in hold");

	// high bits follow input
	property p_high;
		@(posedge SYS_CLK) disable iff (!RST_B)
		1'b1 |=> pipe_r[2][9:5] == $past(pipe_r[1][9:5]);
	endproperty
	a_high: assert property (p_high) else $error("high bits not updated");

	// three-cycle latency outside hold
	property p_lat;
		@(posedge SYS_CLK) disable iff (!RST_B)
		!hold ##1 !hold ##1 !hold ##1 !hold |-> pipe_r[2] == $past(RAW_CODE, 3);
	endproperty
	a_lat: assert property (p_lat) else $error("latency not three");

	// no restart while running
	property p_ign;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(st_r == acc_pkg::CAL_RUN) && seq_r > 4'h1 |=> seq_r == $past(seq_r) + 4'h1;
	endproperty
	a_ign: assert property (p_ign) else $error("run restarted");

	// power-up pulses no closer than one per sixteen clocks
	property p_pwr;
		@(posedge SYS_CLK) disable iff (!RST_B)
		pwr_pulse |=> !pwr_pulse [*8] ##1 !pwr_pulse [*7];
	endproperty
	a_pwr: assert property (p_pwr) else $error("bad power-up pulse");
endmodule : acc_ctrl

/* File: dv/acc_host_model.sv */
`timescale 1ns/1ps
// host side: drives the calibration pin, reads samples
module acc_host_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// commands from the bench
	input  wire logic       fire,
	input  wire logic [3:0] low_len,
	input  wire logic       hold_off,
	// pins toward the block
	output logic            cal_pulse,
	output logic            sample_ready
);
	logic [3:0] low_cnt_r; // low cycles still to go

	// low one clock minimum, else held high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_pulse <= 1'b1;
			low_cnt_r <= 4'h0;
		end else if (fire) begin
			cal_pulse <= 1'b0;
			// a zero length would give the same one-clock low time as a length of one
			low_cnt_r <= (low_len == 4'h0) ? 4'h1 : low_len;
		end else if (low_cnt_r > 4'h1) begin
			low_cnt_r <= low_cnt_r - 4'h1;
		end else begin
			cal_pulse <= 1'b1;
			low_cnt_r <= 4'h0;
		end
	end

	// reader: ready from reset, stalls on request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_ready <= 1'b1;
		end else begin
			sample_ready <= !hold_off;
		end
	end
endmodule : acc_host_model

/* File: dv/adc_calibration_output_control_test.sv */
`timescale 1ns/1ps
// bench: inputs by nba at the rising edge, checks 1ns after
module adc_calibration_output_control_test;
	// next stream word: each half steps on its own, so no carry links them
	function automatic logic [9:0] nxt_word(input logic [9:0] w);
		return {5'(w[9:5] + 5'h01), 5'(w[4:0] + 5'h03)};
	endfunction : nxt_word
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       sel = 1'b0;     // external source
	logic       en_b = 1'b0;
	logic       cal_rst = 1'b0; // power-up held off at first
	logic       fire = 1'b0;
	logic       hold_off = 1'b0;
	logic [3:0] low_len = 4'h1;
	logic [9:0] raw = 10'h0000;
	logic [9:0] code;
	logic [9:0] prev = 10'h0000;
	logic       pin, rdy, valid, busy, hold, done, stall;
	logic [2:0] step;
	logic       watch = 1'b0;   // freeze monitor on
	int         error_cnt = 0;
	int         comparisons = 0;
	int         rep = 0;
	int         reps = 0;       // longest run of stuck low fields

	always #2.5 clk = ~clk;
	// stream one word per clock
	always @(posedge clk) raw <= nxt_word(raw);

	acc_ctrl uut (
		.SYS_CLK         (clk),
		.RST_B           (rst_b),
		.CAL_PULSE       (pin),
		.CAL_SRC_SEL     (sel),
		.CHIP_EN_B       (en_b),
		.CAL_RESET       (cal_rst),
		.RAW_CODE        (raw),
		.SAMPLE_CODE_OUT (code),
		.SAMPLE_VALID    (valid),
		.SAMPLE_READY    (rdy),
		.CAL_BUSY        (busy),
		.CAL_HOLD_ACTIVE (hold),
		.PWRUP_DONE      (done),
		.CAL_STEP        (step),
		.SAMPLE_STALL    (stall)
	);
	acc_host_model host (
		.clk          (clk),
		.rst_b        (rst_b),
		.fire         (fire),
		.low_len      (low_len),
		.hold_off     (hold_off),
		.cal_pulse    (pin),
		.sample_ready (rdy)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	// bounded wait for a busy level
	task automatic wait_busy(input logic lvl, input int bound, output int n);
		n = 0;
		while (busy !== lvl) begin
			tick();
			n++;
			if (n > bound) begin
				chk("busy wait", lvl, busy);
				test_done();
			end
		end
	endtask : wait_busy

	// busy cycles seen over a stretch
	task automatic quiet(input int cyc, output int hits);
		hits = 0;
		repeat (cyc) begin
			tick();
			if (busy !== 1'b0) hits++;
		end
	endtask : quiet

	task automatic pulse(input logic [3:0] len);
		@(posedge clk);
		fire <= 1'b1;
		low_len <= len;
		@(posedge clk);
		fire <= 1'b0;
	endtask : pulse

	// accepted words: high field always moves on
	always @(posedge clk) begin
		if (watch && valid === 1'b1 && rdy === 1'b1) begin
			chk("high field", 5'(prev[9:5] + 5'h01), code[9:5]);
			rep = (code[4:0] === prev[4:0]) ? rep + 1 : 0;
			if (rep > reps) reps = rep;
		end
		if (valid === 1'b1 && rdy === 1'b1) prev = code;
	end

	task automatic t_latency;
		logic [9:0] v;
		int         n;
		@(posedge clk);
		v = nxt_word(raw); // word the stream drives at this edge
		n = 0;
		while (!(valid === 1'b1 && code === v) && n < 20) begin
			tick();
			n++;
		end
		// pipeline stages plus the buffer register
		chk("latency", acc_pkg::LATENCY + 1, n);
		v = nxt_word(v);
		tick();
		chk("next word", v, code);
		$display("latency test done");
	endtask : t_latency

	task automatic t_ext;
		int n, blen, hrise, hlen;
		watch = 1'b1;
		pulse(4'h1);
		wait_busy(1'b1, 10, n);
		chk("edge to busy", 1, n >= 2 && n <= 4);
		blen = 0;
		hrise = 0;
		hlen = 0;
		while (busy === 1'b1 && blen < 20) begin
			// second edge lands mid-run
			fire <= (blen == 2);
			// run cycles are numbered from one
			if (hold === 1'b1 && hlen == 0) hrise = blen + 1;
			if (hold === 1'b1) hlen++;
			blen++;
			tick();
		end
		fire <= 1'b0;
		chk("run length", acc_pkg::CAL_LEN, blen);
		chk("hold start", acc_pkg::CAL_HOLD_AT, hrise);
		chk("hold length", acc_pkg::CAL_HOLD_N, hlen);
		quiet(12, n);
		chk("edge while busy", 0, n);
		watch = 1'b0;
		chk("low field held", acc_pkg::CAL_HOLD_N, reps);
		$display("external test done");
	endtask : t_ext

	task automatic t_sel;
		int h;
		@(posedge clk);
		sel <= 1'b1;
		repeat (3) tick();
		pulse(4'h2);
		quiet(15, h);
		chk("pin ignored", 0, h);
		@(posedge clk);
		sel <= 1'b0;
		$display("select test done");
	endtask : t_sel

	task automatic t_fifo;
		logic [9:0] w;
		int         n, k;
		@(posedge clk);
		hold_off <= 1'b1;
		n = 0;
		while (stall !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		chk("fill to full", 1, stall);
		w = code;
		tick();
		chk("head held", w, code);
		@(posedge clk);
		hold_off <= 1'b0;
		n = 0;
		k = 0;
		while (k < acc_pkg::FIFO_DEPTH && n < 60) begin
			tick();
			n++;
			if (valid === 1'b1 && rdy === 1'b1) begin
				if (k > 0) chk("drain order", nxt_word(w), code);
				w = code;
				k++;
			end
		end
		chk("drained words", acc_pkg::FIFO_DEPTH, k);
		$display("buffer test done");
	endtask : t_fifo

	task automatic t_pwr;
		logic [2:0] s;
		int         n, h;
		@(posedge clk);
		cal_rst <= 1'b1;
		wait_busy(1'b1, 60, n);
		chk("power-up start", 1, busy);
		chk("not yet done", 0, done);
		s = step;
		repeat (8) begin
			wait_busy(1'b0, 20, n);
			wait_busy(1'b1, 30, h);
			chk("pulse spacing", 16, n + h);
			chk("step advance", (s == 3'h6) ? 3'h0 : s + 3'h1, step);
			s = step;
		end
		@(posedge clk);
		cal_rst <= 1'b0;
		repeat (3) tick();
		wait_busy(1'b0, 20, n);
		quiet(40, h);
		chk("reset low stops", 0, h);
		@(posedge clk);
		en_b <= 1'b1;
		cal_rst <= 1'b1;
		quiet(40, h);
		chk("disabled stops", 0, h);
		@(posedge clk);
		en_b <= 1'b0;
		wait_busy(1'b1, 60, n);
		chk("restart", 1, busy);
		$display("power-up test done");
	endtask : t_pwr

	// main sequence
	initial begin
		int h;
		repeat (9) @(posedge clk);
		#1;
		chk("reset busy", 0, busy);
		chk("reset valid", 0, valid);
		chk("reset step", 0, step);
		@(posedge clk);
		rst_b <= 1'b1;
		quiet(40, h);
		chk("pin constant idle", 0, h);
		t_latency();
		t_ext();
		t_sel();
		t_fifo();
		t_pwr();
		test_done();
	end
endmodule : adc_calibration_output_control_test
